// ==== core/dmi_defines.vh ====
// Register offsets, field positions and reset values of the DMA event and request registers
`ifndef DMI_DEFINES_VH
`define DMI_DEFINES_VH
`define DMI_NUM_CH 2
`define DMI_ADDR_W 12
`define DMI_OFF_RAW_XFER 12'h2c0
`define DMI_OFF_RAW_BLOCK 12'h2c8
`define DMI_OFF_RAW_SRC 12'h2d0
`define DMI_OFF_RAW_DST 12'h2d8
`define DMI_OFF_RAW_ERR 12'h2e0
`define DMI_OFF_MSK_XFER 12'h2e8
`define DMI_OFF_MSK_BLOCK 12'h2f0
`define DMI_OFF_MSK_SRC 12'h2f8
`define DMI_OFF_MSK_DST 12'h300
`define DMI_OFF_MSK_ERR 12'h308
`define DMI_OFF_EN_XFER 12'h310
`define DMI_OFF_EN_BLOCK 12'h318
`define DMI_OFF_EN_SRC 12'h320
`define DMI_OFF_EN_DST 12'h328
`define DMI_OFF_EN_ERR 12'h330
`define DMI_OFF_ACK_XFER 12'h338
`define DMI_OFF_ACK_BLOCK 12'h340
`define DMI_OFF_ACK_SRC 12'h348
`define DMI_OFF_ACK_DST 12'h350
`define DMI_OFF_ACK_ERR 12'h358
`define DMI_OFF_SUMMARY 12'h360
`define DMI_OFF_SW_SRC 12'h368
`define DMI_OFF_SW_DST 12'h370
`define DMI_WE_LSB 8
`define DMI_WE_MSB 9
`define DMI_CH_RESET 2'h0
`endif

// ==== core/dmi_event_bank.v ====
// One event type: raw, enable and masked status bits for every channel
module dmi_event_bank (
  // Clock and reset
  input wire mclk_in,
  input wire reset_n_in,
  // Event pulses per channel
  input wire [1:0] event_in,
  // Register writes
  input wire enable_wr_in,
  input wire ack_wr_in,
  input wire [31:0] wdata_in,
  // State
  output reg [1:0] raw_out,
  output reg [1:0] enable_out,
  output wire [1:0] masked_out
);
`include "dmi_defines.vh"

  // Per channel bit slice
  genvar ch;
  generate
    for (ch = 0; ch < `DMI_NUM_CH; ch = ch + 1) begin : g_ch
      // Raw bit ignores the enable; a new event beats a same-cycle clear
      always @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          raw_out[ch] <= 1'b0;
        end else if (event_in[ch]) begin
          raw_out[ch] <= 1'b1;
        end else if (ack_wr_in && wdata_in[ch]) begin
          raw_out[ch] <= 1'b0;
        end
      end
      // Enable bit written only under its write-enable bit
      always @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          enable_out[ch] <= 1'b0;
        end else if (enable_wr_in && wdata_in[`DMI_WE_LSB + ch]) begin
          enable_out[ch] <= wdata_in[ch];
        end
      end
    end
  endgenerate

  // Combinational so a clear drops the masked bit together with the raw bit
  assign masked_out = raw_out & enable_out;
endmodule // dmi_event_bank

// ==== core/dmi_regs.v ====
// Event status, mask, clear, summary and software request registers of a two-channel DMA unit
// Notes on behaviour
// - Five raw event registers, one bit per channel, set regardless of mask.
// - Writing one to a clear bit clears raw and masked bits; zero no effect.
// - Masked status equals raw AND mask per channel and type.
// - Outgoing event signals come from the masked status registers.
// - Mask bit written only when its write-enable bit in 9:8 is set.
// - Mask one unmasks, zero blocks; masks reset to zero.
// - Summary bits 0..4 are OR of each masked register across channels.
// - Clear registers are write-only and read back as zero.
// - Software request bits written only when their write-enable bit in 9:8 is set.
// - Software request ignored when software handshaking not selected for that channel.
// - Bus error during transfer raises error event, cancels transfer, disables channel.
// - Memory source never raises source event; memory destination never raises destination event.
// - Block complete event raised when a block to the destination finishes.
// - Transfer complete event raised when the whole transfer finishes.
module dmi_regs (
  // Clock and reset
  input wire mclk_in,
  input wire reset_n_in,
  // Register port, one access per cycle
  input wire reg_sel_in,
  input wire reg_wr_in,
  input wire [11:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  output reg [31:0] reg_rdata_out,
  output reg reg_unmapped_out,
  // Event sources from the channel engine
  input wire [1:0] block_finish_in,
  input wire [1:0] xfer_finish_in,
  input wire [1:0] src_txn_finish_in,
  input wire [1:0] dst_txn_finish_in,
  input wire [1:0] bus_error_in,
  input wire [1:0] src_is_memory_in,
  input wire [1:0] dst_is_memory_in,
  input wire [1:0] src_sw_hs_in,
  input wire [1:0] dst_sw_hs_in,
  // Channel control back to the engine
  output wire [1:0] chan_cancel_out,
  // Outgoing event lines
  output wire [1:0] xfer_done_event_out,
  output wire [1:0] block_done_event_out,
  output wire [1:0] src_txn_done_event_out,
  output wire [1:0] dst_txn_done_event_out,
  output wire [1:0] error_event_out,
  output wire dma_unit_event_out,
  // Effective software requests
  output wire [1:0] sw_src_request_out,
  output wire [1:0] sw_dst_request_out
);
`include "dmi_defines.vh"

  // Write and read strobes shared by every register
  wire wr = reg_sel_in && reg_wr_in;
  wire rd = reg_sel_in && !reg_wr_in;

  // Per type raw, enable and masked bits from the five banks
  wire [1:0] raw_x, raw_b, raw_s, raw_d, raw_e;
  wire [1:0] en_x, en_b, en_s, en_d, en_e;
  wire [1:0] msk_x, msk_b, msk_s, msk_d, msk_e;
  // Stored software request bits, readable even when not handed on
  reg [1:0] sw_src_request_bits;
  reg [1:0] sw_dst_request_bits;
  // Combined status, bit 0 transfer up to bit 4 error
  wire [4:0] summary;
  wire any_xfer_done;
  wire any_block_done;
  wire any_src_txn_done;
  wire any_dst_txn_done;
  wire any_error;

  // Address decode for the raw status registers
  wire hit_raw_x = (reg_addr_in == `DMI_OFF_RAW_XFER);
  wire hit_raw_b = (reg_addr_in == `DMI_OFF_RAW_BLOCK);
  wire hit_raw_s = (reg_addr_in == `DMI_OFF_RAW_SRC);
  wire hit_raw_d = (reg_addr_in == `DMI_OFF_RAW_DST);
  wire hit_raw_e = (reg_addr_in == `DMI_OFF_RAW_ERR);

  // Address decode for the masked status registers
  wire hit_msk_x = (reg_addr_in == `DMI_OFF_MSK_XFER);
  wire hit_msk_b = (reg_addr_in == `DMI_OFF_MSK_BLOCK);
  wire hit_msk_s = (reg_addr_in == `DMI_OFF_MSK_SRC);
  wire hit_msk_d = (reg_addr_in == `DMI_OFF_MSK_DST);
  wire hit_msk_e = (reg_addr_in == `DMI_OFF_MSK_ERR);

  // Address decode for the enable registers
  wire hit_en_x = (reg_addr_in == `DMI_OFF_EN_XFER);
  wire hit_en_b = (reg_addr_in == `DMI_OFF_EN_BLOCK);
  wire hit_en_s = (reg_addr_in == `DMI_OFF_EN_SRC);
  wire hit_en_d = (reg_addr_in == `DMI_OFF_EN_DST);
  wire hit_en_e = (reg_addr_in == `DMI_OFF_EN_ERR);

  // Address decode for the write-only acknowledge registers
  wire hit_ack_x = (reg_addr_in == `DMI_OFF_ACK_XFER);
  wire hit_ack_b = (reg_addr_in == `DMI_OFF_ACK_BLOCK);
  wire hit_ack_s = (reg_addr_in == `DMI_OFF_ACK_SRC);
  wire hit_ack_d = (reg_addr_in == `DMI_OFF_ACK_DST);
  wire hit_ack_e = (reg_addr_in == `DMI_OFF_ACK_ERR);

  // Address decode for the summary and request registers
  wire hit_sum = (reg_addr_in == `DMI_OFF_SUMMARY);
  wire hit_sw_src = (reg_addr_in == `DMI_OFF_SW_SRC);
  wire hit_sw_dst = (reg_addr_in == `DMI_OFF_SW_DST);

  // Any other offset is flagged as unmapped on access
  wire hit_raw = hit_raw_x | hit_raw_b | hit_raw_s | hit_raw_d | hit_raw_e;
  wire hit_msk = hit_msk_x | hit_msk_b | hit_msk_s | hit_msk_d | hit_msk_e;
  wire hit_en = hit_en_x | hit_en_b | hit_en_s | hit_en_d | hit_en_e;
  wire hit_ack = hit_ack_x | hit_ack_b | hit_ack_s | hit_ack_d | hit_ack_e;
  wire hit_any = hit_raw | hit_msk | hit_en | hit_ack | hit_sum | hit_sw_src | hit_sw_dst;

  // Write strobes per register; acknowledges carry no write enable field
  wire wr_en_x = wr && hit_en_x;
  wire wr_en_b = wr && hit_en_b;
  wire wr_en_s = wr && hit_en_s;
  wire wr_en_d = wr && hit_en_d;
  wire wr_en_e = wr && hit_en_e;
  wire wr_ack_x = wr && hit_ack_x;
  wire wr_ack_b = wr && hit_ack_b;
  wire wr_ack_s = wr && hit_ack_s;
  wire wr_ack_d = wr && hit_ack_d;
  wire wr_ack_e = wr && hit_ack_e;
  wire wr_sw_src = wr && hit_sw_src;
  wire wr_sw_dst = wr && hit_sw_dst;

  // Event qualification: memory sides never raise transaction events
  wire [1:0] ev_x = xfer_finish_in;
  wire [1:0] ev_b = block_finish_in;
  wire [1:0] ev_s = src_txn_finish_in & ~src_is_memory_in;
  wire [1:0] ev_d = dst_txn_finish_in & ~dst_is_memory_in;
  wire [1:0] ev_e = bus_error_in;
  // Error cancels the transfer and disables the channel in the engine
  assign chan_cancel_out = bus_error_in;

  // Transfer complete bank
  dmi_event_bank u_xfer (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .event_in(ev_x),
    .enable_wr_in(wr_en_x),
    .ack_wr_in(wr_ack_x),
    .wdata_in(reg_wdata_in),
    .raw_out(raw_x),
    .enable_out(en_x),
    .masked_out(msk_x)
  );

  // Block complete bank
  dmi_event_bank u_block (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .event_in(ev_b),
    .enable_wr_in(wr_en_b),
    .ack_wr_in(wr_ack_b),
    .wdata_in(reg_wdata_in),
    .raw_out(raw_b),
    .enable_out(en_b),
    .masked_out(msk_b)
  );

  // Source transaction bank
  dmi_event_bank u_src (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .event_in(ev_s),
    .enable_wr_in(wr_en_s),
    .ack_wr_in(wr_ack_s),
    .wdata_in(reg_wdata_in),
    .raw_out(raw_s),
    .enable_out(en_s),
    .masked_out(msk_s)
  );

  // Destination transaction bank
  dmi_event_bank u_dst (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .event_in(ev_d),
    .enable_wr_in(wr_en_d),
    .ack_wr_in(wr_ack_d),
    .wdata_in(reg_wdata_in),
    .raw_out(raw_d),
    .enable_out(en_d),
    .masked_out(msk_d)
  );

  // Error bank
  dmi_event_bank u_err (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .event_in(ev_e),
    .enable_wr_in(wr_en_e),
    .ack_wr_in(wr_ack_e),
    .wdata_in(reg_wdata_in),
    .raw_out(raw_e),
    .enable_out(en_e),
    .masked_out(msk_e)
  );

  // Outgoing lines straight from masked status, no extra latency
  assign xfer_done_event_out = msk_x;
  assign block_done_event_out = msk_b;
  assign src_txn_done_event_out = msk_s;
  assign dst_txn_done_event_out = msk_d;
  assign error_event_out = msk_e;

  // One bit per type in the summary, then one line for the whole unit
  assign any_xfer_done = |msk_x;
  assign any_block_done = |msk_b;
  assign any_src_txn_done = |msk_s;
  assign any_dst_txn_done = |msk_d;
  assign any_error = |msk_e;
  assign summary = {any_error, any_dst_txn_done, any_src_txn_done, any_block_done, any_xfer_done};
  assign dma_unit_event_out = |summary;

  // Software request registers, per-channel write enable
  genvar ch;
  generate
    for (ch = 0; ch < `DMI_NUM_CH; ch = ch + 1) begin : g_req
      // Source request bit
      always @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          sw_src_request_bits[ch] <= 1'b0;
        end else if (wr_sw_src && reg_wdata_in[`DMI_WE_LSB + ch]) begin
          sw_src_request_bits[ch] <= reg_wdata_in[ch];
        end
      end
      // Destination request bit
      always @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          sw_dst_request_bits[ch] <= 1'b0;
        end else if (wr_sw_dst && reg_wdata_in[`DMI_WE_LSB + ch]) begin
          sw_dst_request_bits[ch] <= reg_wdata_in[ch];
        end
      end
    end
  endgenerate

  // Stored bit stays readable, but the engine only sees it under software handshaking
  assign sw_src_request_out = sw_src_request_bits & src_sw_hs_in;
  assign sw_dst_request_out = sw_dst_request_bits & dst_sw_hs_in;

  // Read mux; clear addresses and reserved bits return zero
  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h0000_0000;
    case (reg_addr_in)
      // Raw status
      `DMI_OFF_RAW_XFER: begin
        next_rdata = {30'h0, raw_x};
      end
      `DMI_OFF_RAW_BLOCK: begin
        next_rdata = {30'h0, raw_b};
      end
      `DMI_OFF_RAW_SRC: begin
        next_rdata = {30'h0, raw_s};
      end
      `DMI_OFF_RAW_DST: begin
        next_rdata = {30'h0, raw_d};
      end
      `DMI_OFF_RAW_ERR: begin
        next_rdata = {30'h0, raw_e};
      end
      // Masked status
      `DMI_OFF_MSK_XFER: begin
        next_rdata = {30'h0, msk_x};
      end
      `DMI_OFF_MSK_BLOCK: begin
        next_rdata = {30'h0, msk_b};
      end
      `DMI_OFF_MSK_SRC: begin
        next_rdata = {30'h0, msk_s};
      end
      `DMI_OFF_MSK_DST: begin
        next_rdata = {30'h0, msk_d};
      end
      `DMI_OFF_MSK_ERR: begin
        next_rdata = {30'h0, msk_e};
      end
      // Enables; write enable positions are not stored, so they read zero
      `DMI_OFF_EN_XFER: begin
        next_rdata = {30'h0, en_x};
      end
      `DMI_OFF_EN_BLOCK: begin
        next_rdata = {30'h0, en_b};
      end
      `DMI_OFF_EN_SRC: begin
        next_rdata = {30'h0, en_s};
      end
      `DMI_OFF_EN_DST: begin
        next_rdata = {30'h0, en_d};
      end
      `DMI_OFF_EN_ERR: begin
        next_rdata = {30'h0, en_e};
      end
      // Acknowledges are write-only
      `DMI_OFF_ACK_XFER, `DMI_OFF_ACK_BLOCK, `DMI_OFF_ACK_SRC,
      `DMI_OFF_ACK_DST, `DMI_OFF_ACK_ERR: begin
        next_rdata = 32'h0000_0000;
      end
      // Summary and stored request bits
      `DMI_OFF_SUMMARY: begin
        next_rdata = {27'h0, summary};
      end
      `DMI_OFF_SW_SRC: begin
        next_rdata = {30'h0, sw_src_request_bits};
      end
      `DMI_OFF_SW_DST: begin
        next_rdata = {30'h0, sw_dst_request_bits};
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // Unmapped access of either kind, so a stray store is visible too
  wire next_unmapped = reg_sel_in && !hit_any;

  // Read data registered one cycle after the access; zero otherwise
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (rd) begin
      reg_rdata_out <= next_rdata;
    end else begin
      reg_rdata_out <= 32'h0000_0000;
    end
  end

  // Unmapped flag is a one cycle pulse after the access
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_unmapped_out <= 1'b0;
    end else begin
      reg_unmapped_out <= next_unmapped;
    end
  end
endmodule // dmi_regs

// ==== testbench/dmi_regs_asserts.sv ====
// Port-level checker for the DMA event and request register block
`include "dmi_defines.vh"
module dmi_regs_asserts (
  // Clock, reset and register port
  input wire mclk_in,
  input wire reset_n_in,
  input wire reg_sel_in,
  input wire reg_wr_in,
  input wire [11:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire [31:0] reg_rdata_out,
  input wire reg_unmapped_out,
  // Engine side
  input wire [1:0] xfer_finish_in,
  input wire [1:0] bus_error_in,
  input wire [1:0] src_is_memory_in,
  input wire [1:0] src_sw_hs_in,
  input wire [1:0] chan_cancel_out,
  input wire [1:0] xfer_done_event_out,
  input wire [1:0] block_done_event_out,
  input wire [1:0] src_txn_done_event_out,
  input wire [1:0] dst_txn_done_event_out,
  input wire [1:0] error_event_out,
  input wire dma_unit_event_out,
  input wire [1:0] sw_src_request_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  // Decoded accesses used by several properties
  wire rd_acc = reg_sel_in && !reg_wr_in;
  wire ack_x = reg_sel_in && reg_wr_in && reg_addr_in == `DMI_OFF_ACK_XFER;
  property p_cancel; chan_cancel_out == bus_error_in; endproperty
  a_cancel: assert property (p_cancel) else $error("cancel does not follow bus error");
  property p_sum; dma_unit_event_out == |{xfer_done_event_out, block_done_event_out,
    src_txn_done_event_out, dst_txn_done_event_out, error_event_out}; endproperty
  a_sum: assert property (p_sum) else $error("combined event line wrong");
  property p_clear; ack_x && reg_wdata_in[0] && !xfer_finish_in[0] |=> !xfer_done_event_out[0]; endproperty
  a_clear: assert property (p_clear) else $error("clear write left event set");
  property p_race; ack_x && xfer_finish_in[0] && xfer_done_event_out[0] |=> xfer_done_event_out[0]; endproperty
  a_race: assert property (p_race) else $error("event lost against clear");
  property p_sticky; !reg_sel_in && xfer_done_event_out[0] |=> xfer_done_event_out[0]; endproperty
  a_sticky: assert property (p_sticky) else $error("status dropped without clear");
  property p_srcmem; !reg_sel_in && src_is_memory_in[0] && !src_txn_done_event_out[0]
    |=> !src_txn_done_event_out[0]; endproperty
  a_srcmem: assert property (p_srcmem) else $error("memory source raised source event");
  property p_gate; (sw_src_request_out & ~src_sw_hs_in) == 2'h0; endproperty
  a_gate: assert property (p_gate) else $error("request passed without software handshake");
  property p_idle; !rd_acc |=> reg_rdata_out == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data not zero when idle");
  property p_unmap; rd_acc && reg_addr_in == 12'h004 |=> reg_unmapped_out && reg_rdata_out == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not flagged");
endmodule // dmi_regs_asserts
bind dmi_regs dmi_regs_asserts i_dmi_regs_asserts (.*);

// ==== testbench/tb_dmi_regs.sv ====
// Self-checking bench for the DMA event and request register block
`include "dmi_defines.vh"
module tb_dmi_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 0, reset_n_in = 0, sel = 0, wr = 0;
  logic [11:0] addr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic [9:0] ev = 10'h0;
  logic [1:0] smem = 2'h0, dmem = 2'h0, shs = 2'h0, dhs = 2'h0;
  wire [31:0] rdata;
  wire [9:0] evo;
  wire [1:0] sreq, dreq;
  int mismatches = 0, check_count = 0, i, j;
  // Device under test, events packed five pairs into one vector
  dmi_regs i_dmi_regs (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .reg_sel_in(sel), .reg_wr_in(wr),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_unmapped_out(),
    .xfer_finish_in(ev[1:0]), .block_finish_in(ev[3:2]), .src_txn_finish_in(ev[5:4]),
    .dst_txn_finish_in(ev[7:6]), .bus_error_in(ev[9:8]), .src_is_memory_in(smem), .dst_is_memory_in(dmem),
    .src_sw_hs_in(shs), .dst_sw_hs_in(dhs), .chan_cancel_out(), .xfer_done_event_out(evo[1:0]),
    .block_done_event_out(evo[3:2]), .src_txn_done_event_out(evo[5:4]), .dst_txn_done_event_out(evo[7:6]),
    .error_event_out(evo[9:8]), .dma_unit_event_out(), .sw_src_request_out(sreq), .sw_dst_request_out(dreq));
  initial begin
    forever #20 mclk_in = ~mclk_in;
  end
  // Cuts a hang short
  initial begin
    #400000;
    mismatches++;
    close_out();
  end
  function automatic logic [11:0] at(input logic [11:0] b, input int k);
    return b + 12'(8 * k);
  endfunction
  // One cycle of strobe and event pulse; idle cycle after keeps drivers single-assigned
  task automatic acc(input logic s, w, input logic [11:0] a, input logic [31:0] d, input logic [9:0] e);
    @(posedge mclk_in);
    sel <= s; wr <= w; addr <= a; wdata <= d; ev <= e;
    @(posedge mclk_in);
    sel <= 1'b0; ev <= 10'h0;
    #1;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    acc(1'b1, 1'b0, a, 32'h0, 10'h0);
    chk(rdata, exp);
  endtask
  task automatic close_out();
    if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    for (i = 0; i < 23; i++) rd(at(12'h2c0, i), 32'h0);
    rd(12'h004, 32'h0);
    // Events land in raw while masked, then unmask channel 0 only
    for (i = 0; i < 5; i++) begin
      acc(1'b0, 1'b0, 12'h0, 32'h0, 10'h3 << (2 * i));
      rd(at(12'h2c0, i), 32'h3);
      rd(at(12'h2e8, i), 32'h0);
      acc(1'b1, 1'b1, at(12'h310, i), 32'hffff_fd03, 10'h0);
      rd(at(12'h310, i), 32'h1);
      rd(at(12'h2e8, i), 32'h1);
      chk(32'(evo[2 * i +: 2]), 32'h1);
    end
    rd(`DMI_OFF_SUMMARY, 32'h1f);
    for (i = 0; i < 5; i++) begin
      acc(1'b1, 1'b1, at(12'h338, i), 32'h1, 10'h0);
      rd(at(12'h2c0, i), 32'h2);
      rd(at(12'h2e8, i), 32'h0);
    end
    rd(`DMI_OFF_SUMMARY, 32'h0);
    // Channel 0 set and unmasked first, then cleared while it fires again
    acc(1'b0, 1'b0, 12'h0, 32'h0, 10'h1);
    rd(`DMI_OFF_MSK_XFER, 32'h1);
    acc(1'b1, 1'b1, `DMI_OFF_ACK_XFER, 32'h3, 10'h1);
    rd(`DMI_OFF_RAW_XFER, 32'h1);
    rd(`DMI_OFF_ACK_XFER, 32'h0);
    // Channel 0 is memory on both sides, so its transaction events stay quiet
    @(posedge mclk_in);
    smem <= 2'h1;
    dmem <= 2'h1;
    acc(1'b0, 1'b0, 12'h0, 32'h0, 10'h0f0);
    rd(`DMI_OFF_RAW_SRC, 32'h2);
    rd(`DMI_OFF_RAW_DST, 32'h2);
    for (j = 0; j < 2; j++) begin
      acc(1'b1, 1'b1, at(`DMI_OFF_SW_SRC, j), 32'hffff_fe03, 10'h0);
      rd(at(`DMI_OFF_SW_SRC, j), 32'h2);
      acc(1'b1, 1'b1, at(`DMI_OFF_SW_SRC, j), 32'h0000_00ff, 10'h0);
      rd(at(`DMI_OFF_SW_SRC, j), 32'h2);
    end
    chk(32'({sreq, dreq}), 32'h0);
    @(posedge mclk_in);
    shs <= 2'h3;
    dhs <= 2'h1;
    @(posedge mclk_in);
    #1;
    chk(32'({sreq, dreq}), 32'h8);
    close_out();
  end
endmodule // tb_dmi_regs
